// >>> src/nvm_access_defs.vh
// Constants for the nonvolatile memory access controller
`ifndef NVM_ACCESS_DEFS_VH
`define NVM_ACCESS_DEFS_VH

// Command codes
`define CMD_PAGE_DATA_HI 4'hB
`define CMD_RESTORE_DEFAULT 8'h12
`define CMD_STORE_USER 8'h15
`define CMD_RESTORE_USER 8'h16
`define CMD_ADDR_OFFSET 8'hD3
`define CMD_PAGE_ERASE 8'hD4
`define CMD_PASSWORD 8'hD5

// Memory geometry
`define PAGE_FACTORY 4'h0
`define PAGE_USER 4'h1
`define PAGE_READ_FREE_MIN 4'h2
`define PAGE_WRITE_MIN 4'h4
`define MAX_BLOCK_BYTES 9'h100
`define CFG_BYTES 9'h020
`define ERASED_BYTE 8'hFF

// Reset values
`define PASSWORD_RESET 8'hFF
`define OFFSET_RESET 9'h000

// Status bit of the unlocked flag
`define STATUS_UNLOCKED_BIT 4

// Timing: 35 ms page erase at 25 MHz
`define CLK_HZ 25000000
`define ERASE_MS 35
`define ERASE_CYCLES ((`CLK_HZ / 1000) * `ERASE_MS)

// FIFO shape
`define FIFO_WIDTH 8
`define FIFO_DEPTH 4

`endif

// >>> src/byte_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4
)
(
	// Clock and control
	input wire clk_sys,
	input wire rst_n,
	input wire clk_en,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

localparam AW = (DEPTH <= 2) ? 1 : $clog2(DEPTH);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] count;
reg space;
wire [AW:0] next_count;
wire push;
wire pop;

// Ready comes from a flop so the host side never sees a combinational path
assign in_ready = space;
assign out_valid = (count != {(AW+1){1'b0}});
assign out_data = mem[rd_ptr];
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;
assign next_count = (push && !pop) ? count + 1'b1 : ((pop && !push) ? count - 1'b1 : count);

always @(posedge clk_sys)
begin
	if (!rst_n)
	begin
		wr_ptr <= {AW{1'b0}};
		rd_ptr <= {AW{1'b0}};
		count <= {(AW+1){1'b0}};
		space <= 1'b1;
	end
	else if (clk_en)
	begin
		if (push)
		begin
			mem[wr_ptr] <= in_data;
			wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
		end
		if (pop)
			rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
		count <= next_count;
		space <= (next_count != DEPTH[AW:0]);
	end
end

endmodule

// >>> src/nvm_write_lock.v
// Nonvolatile memory write, lock and settings transfer controller
`timescale 1ns/1ns
`include "nvm_access_defs.vh"

// Function
// RULE1: Writes to pages four to fifteen accepted only when unlocked.
// RULE2: Page data commands write one byte or a run of consecutive bytes.
// RULE3: Offset command, two bytes high first, sets first written byte position.
// RULE4: Host erases a target page before rewriting it.
// RULE5: One block write carries at most 256 data bytes.
// RULE6: Locked after reset; only reads of pages two to fifteen allowed.
// RULE7: Unlocked permits read, write and erase within page restrictions.
// RULE8: Pages zero and one unreadable until unlocked.
// RULE9: Two consecutive correct password writes unlock; factory password all ones.
// RULE10: Unlock sets the unlocked status flag at bit four.
// RULE11: Wrong password byte locks and clears the unlocked flag.
// RULE12: Correct password then new value changes the password.
// RULE13: After reset user settings from page one load into config registers.
// RULE14: Restore user command reloads config from page one.
// RULE15: Restore default loads page zero and resets password to all ones.
// RULE16: Register contents are never saved into page zero.
// RULE17: Store user command saves config into page one when unlocked.
// RULE18: Store erases page one then programs it; busy for 35 ms.
// RULE19: Erase command erases the selected whole page; busy 35 ms.
// RULE20: Data writes to page zero or one are refused with a nack.
// RULE21: Erase sets all bits high; programming only clears bits.
// RULE22: Target page comes from low four bits of page data command.
// RULE23: Locked device rejects writes and erases, flag stays clear.
module nvm_write_lock #(
	parameter ERASE_CYCLES = `ERASE_CYCLES
)
(
	// Clock, reset and enable
	input wire clk_sys,
	input wire rst_n,
	input wire clk_en,
	// Decoded bus transaction stream
	input wire cmd_start,
	input wire [7:0] cmd_code,
	input wire byte_valid,
	input wire [7:0] byte_data,
	output wire byte_ready,
	input wire cmd_end,
	// Read permission query
	input wire [3:0] rd_page,
	output reg rd_allowed,
	// Answer to the bus side
	output reg nack,
	output reg busy,
	output reg [7:0] status,
	// Memory array port
	output reg mem_we,
	output reg mem_erase,
	output reg [12:0] mem_addr,
	output reg [7:0] mem_wdata,
	output reg mem_re,
	input wire [7:0] mem_rdata,
	// Configuration register port
	output reg cfg_we,
	output reg [4:0] cfg_addr,
	output reg [7:0] cfg_wdata,
	input wire [7:0] cfg_rdata
);

////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 3'd0;
localparam ST_ERASE = 3'd1;
localparam ST_LOAD_RD = 3'd2;
localparam ST_LOAD_WR = 3'd3;
localparam ST_STORE = 3'd4;
localparam ST_WAIT = 3'd5;

reg [2:0] state;
reg unlocked;
reg pw_half;
reg pw_change;
reg [7:0] password;
reg [8:0] offset;
reg off_hi_seen;
reg [3:0] page;
reg [8:0] wr_pos;
reg [8:0] wr_count;
reg wr_active;
reg [7:0] held_cmd;
reg [3:0] xfer_page;
reg [8:0] xfer_idx;
reg [31:0] timer;
reg store_after;
reg byte_hold;

wire fifo_in_ready;
wire fifo_out_valid;
wire [7:0] fifo_out_data;
wire fifo_pop;
wire is_data_cmd;
wire write_ok;

// Stall the host only when the FIFO is full, as happens while the array is busy; bytes past the block cap are taken and nacked
assign byte_ready = fifo_in_ready;

byte_fifo #(
	.WIDTH(`FIFO_WIDTH),
	.DEPTH(`FIFO_DEPTH)
)
u_fifo (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.clk_en(clk_en),
	.in_valid(byte_valid),
	.in_ready(fifo_in_ready),
	.in_data(byte_data),
	.out_valid(fifo_out_valid),
	.out_ready(fifo_pop),
	.out_data(fifo_out_data)
);

// RULE22: page from code
assign is_data_cmd = (held_cmd[7:4] == `CMD_PAGE_DATA_HI);
// RULE1: unlocked free page
assign write_ok = unlocked && (page >= `PAGE_WRITE_MIN);
// Host bytes are only popped and programmed in idle, so bytes wait in the FIFO otherwise
assign fifo_pop = fifo_out_valid && (state == ST_IDLE) && !byte_hold;

////////////////////////////////////////////////////////////////////////
always @(posedge clk_sys)
begin
	if (!rst_n)
	begin
		// RULE6: locked at reset
		unlocked <= 1'b0;
		pw_half <= 1'b0;
		pw_change <= 1'b0;
		password <= `PASSWORD_RESET;
		offset <= `OFFSET_RESET;
		off_hi_seen <= 1'b0;
		wr_active <= 1'b0;
		held_cmd <= 8'h00;
		// RULE13: load user page at reset
		state <= ST_LOAD_RD;
		xfer_page <= `PAGE_USER;
		xfer_idx <= 9'h000;
		byte_hold <= 1'b0;
		nack <= 1'b0;
		busy <= 1'b1;
		status <= 8'h00;
		rd_allowed <= 1'b0;
		mem_we <= 1'b0;
		mem_erase <= 1'b0;
		mem_re <= 1'b0;
		cfg_we <= 1'b0;
	end
	else if (clk_en)
	begin
		mem_we <= 1'b0;
		mem_erase <= 1'b0;
		mem_re <= 1'b0;
		cfg_we <= 1'b0;
		byte_hold <= 1'b0;
		// RULE10: flag mirrors lock
		status <= {7'h00, unlocked} << `STATUS_UNLOCKED_BIT;
		// RULE8: settings pages hidden
		rd_allowed <= unlocked || (rd_page >= `PAGE_READ_FREE_MIN);
		if (cmd_start)
		begin
			held_cmd <= cmd_code;
			page <= cmd_code[3:0];
			wr_pos <= offset;
			wr_count <= 9'h000;
			wr_active <= 1'b1;
			off_hi_seen <= 1'b0;
			nack <= 1'b0;
		end
		if (cmd_end)
			wr_active <= 1'b0;
		case (state)
		ST_IDLE:
		begin
			busy <= 1'b0;
			xfer_idx <= 9'h000;
			if (fifo_pop && wr_active)
			begin
				if (is_data_cmd)
				begin
					// RULE20: settings pages nack
					if (page < `PAGE_READ_FREE_MIN)
						nack <= 1'b1;
					// RULE23: locked refuse write
					else if (!write_ok)
						nack <= 1'b1;
					// RULE5: 256 byte cap
					else if (wr_count == `MAX_BLOCK_BYTES)
						nack <= 1'b1;
					else
					begin
						// RULE2: program consecutive bytes
						mem_we <= 1'b1;
						mem_addr <= {page, wr_pos};
						mem_wdata <= fifo_out_data;
						wr_pos <= wr_pos + 9'h001;
						wr_count <= wr_count + 9'h001;
					end
				end
				else if (held_cmd == `CMD_ADDR_OFFSET)
				begin
					// RULE3: high byte first
					if (!off_hi_seen)
						offset[8] <= fifo_out_data[0];
					else
						offset[7:0] <= fifo_out_data;
					off_hi_seen <= 1'b1;
				end
				else if (held_cmd == `CMD_PAGE_ERASE)
				begin
					// RULE19: whole page erase
					if (unlocked && fifo_out_data[3:0] >= `PAGE_WRITE_MIN && fifo_out_data[7:4] == 4'h0)
					begin
						mem_erase <= 1'b1;
						mem_addr <= {fifo_out_data[3:0], 9'h000};
						timer <= ERASE_CYCLES - 1;
						store_after <= 1'b0;
						busy <= 1'b1;
						state <= ST_ERASE;
					end
					// RULE7: erase only when open
					else
						nack <= 1'b1;
				end
				else if (held_cmd == `CMD_PASSWORD)
				begin
					// RULE12: adopt new password
					if (pw_change)
					begin
						password <= fifo_out_data;
						pw_change <= 1'b0;
						pw_half <= 1'b0;
					end
					// RULE9: second correct write
					else if (fifo_out_data == password)
					begin
						pw_half <= 1'b1;
						unlocked <= unlocked || pw_half;
						pw_change <= unlocked;
					end
					// RULE11: wrong byte locks
					else
					begin
						unlocked <= 1'b0;
						pw_half <= 1'b0;
						pw_change <= 1'b0;
					end
				end
			end
			else if (cmd_end && !cmd_start)
			begin
				if (held_cmd == `CMD_RESTORE_USER)
				begin
					// RULE14: reload user page
					xfer_page <= `PAGE_USER;
					busy <= 1'b1;
					state <= ST_LOAD_RD;
				end
				else if (held_cmd == `CMD_RESTORE_DEFAULT)
				begin
					// RULE15: factory load, password reset
					xfer_page <= `PAGE_FACTORY;
					password <= `PASSWORD_RESET;
					busy <= 1'b1;
					state <= ST_LOAD_RD;
				end
				else if (held_cmd == `CMD_STORE_USER)
				begin
					// RULE17: store needs unlock
					if (unlocked)
					begin
						// RULE18: erase then program
						// RULE16: target fixed to user page
						mem_erase <= 1'b1;
						mem_addr <= {`PAGE_USER, 9'h000};
						timer <= ERASE_CYCLES - 1;
						store_after <= 1'b1;
						busy <= 1'b1;
						state <= ST_ERASE;
					end
					else
						nack <= 1'b1;
				end
			end
		end
		ST_ERASE:
		begin
			// RULE21: erase then clear bits
			if (timer == 32'h0000_0000)
			begin
				state <= store_after ? ST_STORE : ST_IDLE;
			end
			else
				timer <= timer - 32'h0000_0001;
		end
		ST_LOAD_RD:
		begin
			mem_re <= 1'b1;
			mem_addr <= {xfer_page, xfer_idx};
			state <= ST_WAIT;
		end
		ST_WAIT:
			state <= ST_LOAD_WR;
		ST_LOAD_WR:
		begin
			// Memory data is registered, so it is valid one cycle after the read strobe
			cfg_we <= 1'b1;
			cfg_addr <= xfer_idx[4:0];
			cfg_wdata <= mem_rdata;
			xfer_idx <= xfer_idx + 9'h001;
			state <= (xfer_idx == `CFG_BYTES - 9'h001) ? ST_IDLE : ST_LOAD_RD;
		end
		ST_STORE:
		begin
			cfg_addr <= xfer_idx[4:0];
			byte_hold <= 1'b1;
			if (byte_hold)
			begin
				mem_we <= 1'b1;
				mem_addr <= {`PAGE_USER, xfer_idx};
				mem_wdata <= cfg_rdata;
				xfer_idx <= xfer_idx + 9'h001;
				byte_hold <= 1'b0;
				if (xfer_idx == `CFG_BYTES - 9'h001)
					state <= ST_IDLE;
			end
		end
		default:
			state <= ST_IDLE;
		endcase
	end
end

endmodule

// >>> test/nvm_write_lock_monitor.sv
// Assertion checker for the memory access controller
`timescale 1ns/1ns
module nvm_write_lock_monitor #(
	parameter ERASE_CYCLES = 20
)
(
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Watched ports
	input wire cmd_start,
	input wire [3:0] rd_page,
	input wire rd_allowed,
	input wire nack,
	input wire busy,
	input wire [7:0] status,
	input wire mem_we,
	input wire mem_erase,
	input wire mem_re,
	input wire [12:0] mem_addr
);
default clocking cb @(posedge clk_sys);
endclocking
default disable iff (!rst_n);
////////////////////////////////////////
sequence s_erase;
	mem_erase;
endsequence
sequence s_busy_soon;
	##[0:1] busy;
endsequence
a_locked_no_write: assert property (mem_we |-> status[4])
	else $error("write while locked");
a_factory_page_kept: assert property (mem_we |-> mem_addr[12:9] != 4'h0)
	else $error("write to factory page");
a_user_page_store: assert property (mem_we && mem_addr[12:9] == 4'h1 |-> busy)
	else $error("user page written outside store");
a_erase_page_ok: assert property (mem_erase |-> status[4] && (mem_addr[12:9] == 4'h1 || mem_addr[12:9] >= 4'h4))
	else $error("bad erase");
a_erase_busy: assert property (s_erase |-> s_busy_soon)
	else $error("erase without busy");
a_status_bits: assert property ((status & 8'hEF) == 8'h00)
	else $error("status stray bits");
a_nack_clear: assert property (cmd_start |=> !nack)
	else $error("nack not cleared");
a_read_perm: assert property ($past(rst_n) |-> rd_allowed == ($past(rd_page) >= 4'h2 || status[4]))
	else $error("read permission wrong");
a_load_busy: assert property (mem_re |-> busy)
	else $error("load read while idle");
endmodule
bind nvm_write_lock nvm_write_lock_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) i_nvm_write_lock_monitor (.clk_sys, .rst_n,
	.cmd_start, .rd_page, .rd_allowed, .nack, .busy, .status, .mem_we, .mem_erase, .mem_re, .mem_addr);

// >>> test/nvm_mem_model.sv
// Memory array and configuration register model
`timescale 1ns/1ns
module nvm_mem_model (
	// Clock
	input wire clk_sys,
	// Memory array port
	input wire mem_we,
	input wire mem_erase,
	input wire mem_re,
	input wire [12:0] mem_addr,
	input wire [7:0] mem_wdata,
	output wire [7:0] mem_rdata,
	// Configuration register port
	input wire cfg_we,
	input wire [4:0] cfg_addr,
	input wire [7:0] cfg_wdata,
	output wire [7:0] cfg_rdata
);
reg [7:0] mem [0:8191];
reg [7:0] cfg [0:31];
reg [7:0] rq = 8'h00;
reg r1 = 0;
integer a;
initial
begin
	for (a = 0; a < 8192; a = a + 1)
		mem[a] = a < 512 ? 8'h80 ^ a[7:0] : a < 1024 ? 8'h40 ^ a[7:0] : 8'h00;
	for (a = 0; a < 32; a = a + 1)
		cfg[a] = 8'h00;
end
// Data is registered at the edge that sees the strobe and stands one cycle; otherwise garbage
assign mem_rdata = r1 ? rq : ~rq;
assign cfg_rdata = cfg[cfg_addr];
always @(posedge clk_sys)
begin
	r1 <= mem_re;
	if (mem_re)
		rq <= mem[mem_addr];
	if (mem_erase)
		for (a = 0; a < 512; a = a + 1)
			mem[{mem_addr[12:9], a[8:0]}] <= 8'hFF;
	if (mem_we)
		mem[mem_addr] <= mem[mem_addr] & mem_wdata;
	if (cfg_we)
		cfg[cfg_addr] <= cfg_wdata;
end
endmodule

// >>> test/tb_top.sv
// Self-checking testbench for the memory access controller
`timescale 1ns/1ns
`include "nvm_access_defs.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_top;
int err_total = 0;
int comparisons = 0;
logic clk_sys = 0;
logic rst_n = 0;
logic clk_en = 1;
logic cmd_start = 0;
logic [7:0] cmd_code = 8'h00;
logic byte_valid = 0;
logic [7:0] byte_data = 8'h00;
logic cmd_end = 0;
logic [3:0] rd_page = 4'h0;
wire byte_ready, rd_allowed, nack, busy, mem_we, mem_erase, mem_re, cfg_we;
wire [7:0] status, mem_wdata, mem_rdata, cfg_wdata, cfg_rdata;
wire [12:0] mem_addr;
wire [4:0] cfg_addr;
nvm_write_lock #(.ERASE_CYCLES(20)) i_nvm_write_lock (.clk_sys, .rst_n, .clk_en, .cmd_start, .cmd_code, .byte_valid,
	.byte_data, .byte_ready, .cmd_end, .rd_page, .rd_allowed, .nack, .busy, .status, .mem_we, .mem_erase, .mem_addr,
	.mem_wdata, .mem_re, .mem_rdata, .cfg_we, .cfg_addr, .cfg_wdata, .cfg_rdata);
nvm_mem_model i_nvm_mem_model (.clk_sys, .mem_we, .mem_erase, .mem_re, .mem_addr, .mem_wdata, .mem_rdata, .cfg_we,
	.cfg_addr, .cfg_wdata, .cfg_rdata);
////////////////////////////////////////
initial
	forever #20 clk_sys = ~clk_sys;
task report_and_stop;
	$display("errors %0d comparisons %0d", err_total, comparisons);
	if (err_total == 0 && comparisons > 0)
		$display("verification passed");
	else
		$display("verification failed");
	$finish;
endtask
task idle;
	int c;
	c = 0;
	repeat (4) @(negedge clk_sys);
	while (busy !== 1'b0 && c < 2000)
	begin
		@(negedge clk_sys);
		c++;
	end
	if (c == 2000)
		err_total++;
endtask
// Bytes are d, d+s, d+2s; the host waits for the buffer to drain before the stop
task send(input logic [7:0] code, input int n, input logic [7:0] d, input logic [7:0] s);
	int k;
	k = 0;
	@(negedge clk_sys);
	cmd_start = 1;
	cmd_code = code;
	@(negedge clk_sys);
	cmd_start = 0;
	byte_valid = n > 0;
	byte_data = d;
	while (k < n)
	begin
		#5;
		if (byte_ready === 1'b1)
		begin
			k++;
			d = d + s;
		end
		@(negedge clk_sys);
		byte_valid = k < n;
		byte_data = d;
	end
	idle;
	cmd_end = 1;
	@(negedge clk_sys);
	cmd_end = 0;
	idle;
endtask
task rd(input logic [3:0] p, input logic e);
	@(negedge clk_sys);
	rd_page = p;
	@(negedge clk_sys);
	`CHK(rd_allowed, e)
endtask
////////////////////////////////////////
task t_powerup;
	`CHK(i_nvm_mem_model.cfg[0], 8'h40)
	`CHK(i_nvm_mem_model.cfg[31], 8'h5F)
	`CHK(status, 8'h00)
endtask
task t_locked;
	rd(4'h0, 1'b0);
	rd(4'h3, 1'b1);
	send(8'hB9, 1, 8'h11, 8'h01);
	`CHK(nack, 1'b1)
	send(`CMD_PAGE_ERASE, 1, 8'h09, 8'h00);
	`CHK(nack, 1'b1)
	send(`CMD_STORE_USER, 0, 8'h00, 8'h00);
	`CHK(nack, 1'b1)
	`CHK(i_nvm_mem_model.mem[9 * 512], 8'h00)
	`CHK(i_nvm_mem_model.mem[515], 8'h43)
endtask
task t_unlock_write;
	send(`CMD_PASSWORD, 1, 8'hFF, 8'h00);
	send(`CMD_PASSWORD, 1, 8'hFF, 8'h00);
	`CHK(status, 8'h10)
	rd(4'h0, 1'b1);
	send(`CMD_PAGE_ERASE, 1, 8'h09, 8'h00);
	`CHK(i_nvm_mem_model.mem[9 * 512 + 5], 8'hFF)
	send(`CMD_ADDR_OFFSET, 2, 8'h01, 8'hFF);
	send(8'hB9, 4, 8'h11, 8'h01);
	`CHK(nack, 1'b0)
	for (int k = 0; k < 4; k++)
		`CHK(i_nvm_mem_model.mem[9 * 512 + 256 + k], 8'h11 + k)
	send(8'hB1, 1, 8'h00, 8'h00);
	`CHK(nack, 1'b1)
	`CHK(i_nvm_mem_model.mem[512], 8'h40)
	send(`CMD_PAGE_ERASE, 1, 8'h02, 8'h00);
	`CHK(nack, 1'b1)
endtask
task t_block_limit;
	send(`CMD_PAGE_ERASE, 1, 8'h0A, 8'h00);
	send(`CMD_ADDR_OFFSET, 2, 8'h00, 8'h00);
	send(8'hBA, 257, 8'h00, 8'h01);
	`CHK(nack, 1'b1)
	`CHK(i_nvm_mem_model.mem[10 * 512 + 254], 8'hFE)
	`CHK(i_nvm_mem_model.mem[10 * 512 + 256], 8'hFF)
endtask
// Bytes wait in the buffer while an erase runs, then land in the erased page
task t_busy;
	@(negedge clk_sys);
	cmd_start = 1;
	cmd_code = `CMD_PAGE_ERASE;
	@(negedge clk_sys);
	cmd_start = 0;
	byte_valid = 1;
	byte_data = 8'h0B;
	@(negedge clk_sys);
	byte_valid = 0;
	@(negedge clk_sys);
	`CHK(busy, 1'b1)
	cmd_end = 1;
	@(negedge clk_sys);
	cmd_end = 0;
	cmd_start = 1;
	cmd_code = 8'hBB;
	@(negedge clk_sys);
	cmd_start = 0;
	byte_valid = 1;
	byte_data = 8'h21;
	repeat (4) @(negedge clk_sys);
	`CHK(byte_ready, 1'b0)
	byte_valid = 0;
	idle;
	idle;
	cmd_end = 1;
	@(negedge clk_sys);
	cmd_end = 0;
	idle;
	`CHK(nack, 1'b0)
	`CHK(i_nvm_mem_model.mem[11 * 512 + 3], 8'h21)
	`CHK(i_nvm_mem_model.mem[11 * 512 + 4], 8'hFF)
endtask
task t_settings;
	@(negedge clk_sys);
	i_nvm_mem_model.cfg[3] = 8'hC3;
	send(`CMD_STORE_USER, 0, 8'h00, 8'h00);
	`CHK(i_nvm_mem_model.mem[515], 8'hC3)
	send(`CMD_RESTORE_DEFAULT, 0, 8'h00, 8'h00);
	`CHK(i_nvm_mem_model.cfg[3], 8'h83)
	send(`CMD_RESTORE_USER, 0, 8'h00, 8'h00);
	`CHK(i_nvm_mem_model.cfg[3], 8'hC3)
endtask
task t_password;
	send(`CMD_PASSWORD, 1, 8'hFF, 8'h00);
	send(`CMD_PASSWORD, 1, 8'h5A, 8'h00);
	send(`CMD_PASSWORD, 1, 8'h00, 8'h00);
	`CHK(status, 8'h00)
	send(`CMD_PASSWORD, 1, 8'h5A, 8'h00);
	send(`CMD_PASSWORD, 1, 8'h5A, 8'h00);
	`CHK(status, 8'h10)
	send(`CMD_PASSWORD, 1, 8'h00, 8'h00);
	send(`CMD_PASSWORD, 1, 8'hFF, 8'h00);
	send(`CMD_PASSWORD, 1, 8'hFF, 8'h00);
	`CHK(status, 8'h00)
	send(`CMD_RESTORE_DEFAULT, 0, 8'h00, 8'h00);
	send(`CMD_PASSWORD, 1, 8'hFF, 8'h00);
	send(`CMD_PASSWORD, 1, 8'hFF, 8'h00);
	`CHK(status, 8'h10)
endtask
initial
begin
	repeat (5) @(negedge clk_sys);
	rst_n = 1;
	idle;
	t_powerup;
	t_locked;
	t_unlock_write;
	t_block_limit;
	t_busy;
	t_settings;
	t_password;
	report_and_stop;
end
// Whole run needs little more than a thousand cycles; the 20000-cycle limit leaves ample margin
initial
begin
	#(20000 * 40);
	err_total++;
	report_and_stop;
end
endmodule
